// ### pkg/bra_defs.svh
`ifndef BRA_DEFS_SVH
`define BRA_DEFS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define BRA_CTRL_OFS 8'h00
`define BRA_STAT_OFS 8'h04
`define BRA_CTRL_RLE 0
`define BRA_CTRL_DROPEN 1
`define BRA_CTRL_PINSEL 2
`define BRA_CTRL_RST 3'h0
`define BRA_STAT_REL 0
`define BRA_STAT_ACK 1
`define BRA_STAT_DROP 2
`define BRA_STAT_OWN 3
// ----------------------------------------
// timing
// ----------------------------------------
`define BRA_DROP_HALF_CLKS 3
`define BRA_DROP_CYC ((`BRA_DROP_HALF_CLKS + 1) / 2)
`define BRA_RESP_OKAY 2'h0
`define BRA_RESP_SLVERR 2'h2
`endif

// ### pkg/bra_pkg.sv
package bra_pkg;
   // ----------------------------------------
   // states and modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      REL_IDLE = 2'h0,
      REL_HELD = 2'h1,
      REL_RET = 2'h3
   } bra_rel_e;
   typedef enum logic [1:0] {
      OWN_CPU = 2'h0,
      OWN_DTC = 2'h1,
      OWN_DMA = 2'h3
   } bra_own_e;
   typedef enum logic [1:0] {
      DMA_SINGLE = 2'h0,
      DMA_STEAL = 2'h1,
      DMA_BLOCK = 2'h2,
      DMA_BURST = 2'h3
   } bra_dma_mode_e;
   // ----------------------------------------
   // internal master requests
   // ----------------------------------------
   typedef struct packed {
      logic dma_req;
      bra_dma_mode_e dma_mode;
      logic dma_xfer_done;
      logic dma_block_done;
      logic dma_all_done;
      logic dtc_req;
      logic dtc_step_done;
      logic cpu_cycle_end;
      logic cpu_split_busy;
      logic cpu_sleep;
   } bra_mst_s;
   typedef struct packed {
      logic dma;
      logic data_transfer_ctrl;
      logic cpu;
   } bra_grant_s;
endpackage

// ### verilog/bra_arbiter.sv
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "bra_defs.svh"
// Operation
// - release granted only in expanded mode with release enable set
// - low request sampled: acknowledge low, bus pins float
// - internal masters keep using internal bus while released
// - internal external access waits until outside request withdrawn
// - refresh waits while external bus is released
// - drop output low during release on pending access or refresh
// - request high ends release, acknowledge returns high
// - drop output returns high 1.5 clocks after acknowledge rises (rounded up here: high 2 clocks after)
// - release beats simultaneous internal external access
// - refresh beats release; refresh and external access run together
// - pin select bit picks which pin carries drop output
// - released: address, data, strobes float, DMA acknowledges high
// - highest requesting master acknowledged, keeps bus until withdrawn
// - CPU yields only between bus cycles, never inside split access
// - sleeping CPU yields at once
// - transfer controller yields only after a complete step
// - DMA single and cycle-steal modes yield after each transfer
// - DMA block mode yields per block, burst at completion
// - release only after current external bus cycle ends
// - reset aborts everything and enters the reset state
module bra_arbiter (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // chip mode and external bus activity
   input wire logic ext_expanded,
   input wire logic ext_access_req,
   input wire logic ext_cycle_busy,
   input wire logic refresh_req,
   // internal masters
   input wire bra_pkg::bra_mst_s mst,
   output bra_pkg::bra_grant_s grant,
   // external bus handshake pins
   input wire logic ext_bus_request_n,
   output logic ext_bus_ack_n,
   output logic request_drop_n,
   output logic request_drop_a_oe_n,
   output logic request_drop_b_oe_n,
   // external bus control
   output logic bus_oe_n,
   output logic dma_ack_force_high,
   output logic ext_cycle_go,
   output logic refresh_go
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      bra_pkg::bra_rel_e rel;
      logic [1:0] cnt;
      bra_pkg::bra_own_e own;
      logic [2:0] ctrl;
      logic aw_ok;
      logic w_ok;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic ack_n;
      logic drop_n;
      logic drop_a_oe_n;
      logic drop_b_oe_n;
      logic go_ext;
      logic go_rfsh;
      logic bus_oe_n;
      logic dma_hi;
      bra_pkg::bra_grant_s grant;
   } bra_state_s;

   bra_state_s q;
   bra_state_s d;
   logic rel_ok;
   logic rel_start;
   logic dma_yield;
   logic own_free;
   logic [1:0] drop_cnt_init;

   assign drop_cnt_init = 2'(`BRA_DROP_CYC - 1);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      d = q;
      // request honoured only when enabled in expanded mode
      rel_ok = ext_expanded && q.ctrl[`BRA_CTRL_RLE]
         && !ext_bus_request_n;
      // refresh wins; wait for the running external cycle
      rel_start = rel_ok && !refresh_req
         && !ext_cycle_busy;

      // release handshake
      case (q.rel)
         bra_pkg::REL_IDLE: begin
            d.drop_n = 1'b1;
            if (rel_start) begin
               d.rel = bra_pkg::REL_HELD;
            end
         end
         bra_pkg::REL_HELD: begin
            // ask the outside master to let go
            d.drop_n = !(q.ctrl[`BRA_CTRL_DROPEN]
               && (ext_access_req || refresh_req));
            if (ext_bus_request_n) begin
               d.rel = bra_pkg::REL_RET;
               d.cnt = drop_cnt_init;
            end
         end
         bra_pkg::REL_RET: begin
            // drop output holds until its delay has run out
            if (q.cnt == 2'h0) begin
               d.drop_n = 1'b1;
               d.rel = bra_pkg::REL_IDLE;
            end else begin
               d.cnt = q.cnt - 2'h1;
            end
         end
         default: begin
            d.rel = bra_pkg::REL_IDLE;
            d.drop_n = 1'b1;
         end
      endcase
      d.ack_n = (d.rel != bra_pkg::REL_HELD);
      // accesses and refresh only start with the bus in hand
      d.go_ext = ext_access_req && !rel_start
         && d.rel == bra_pkg::REL_IDLE;
      d.go_rfsh = refresh_req
         && d.rel == bra_pkg::REL_IDLE;
      // float and force-high flop beside the acknowledge itself
      d.bus_oe_n = !d.ack_n;
      d.dma_hi = !d.ack_n;

      // internal arbitration; release does not stop it
      case (mst.dma_mode)
         bra_pkg::DMA_SINGLE: dma_yield = mst.dma_xfer_done;
         bra_pkg::DMA_STEAL: dma_yield = mst.dma_xfer_done;
         bra_pkg::DMA_BLOCK: dma_yield = mst.dma_block_done;
         bra_pkg::DMA_BURST: dma_yield = mst.dma_all_done;
         default: dma_yield = 1'b0;
      endcase
      case (q.own)
         bra_pkg::OWN_DMA: own_free = !mst.dma_req || dma_yield;
         bra_pkg::OWN_DTC:
            own_free = !mst.dtc_req || mst.dtc_step_done;
         bra_pkg::OWN_CPU: own_free = mst.cpu_sleep
            || (mst.cpu_cycle_end && !mst.cpu_split_busy);
         default: own_free = 1'b1;
      endcase
      if (own_free) begin
         if (mst.dma_req) begin
            d.own = bra_pkg::OWN_DMA;
         end else if (mst.dtc_req) begin
            d.own = bra_pkg::OWN_DTC;
         end else begin
            d.own = bra_pkg::OWN_CPU;
         end
      end
      d.grant.dma = (d.own == bra_pkg::OWN_DMA);
      d.grant.data_transfer_ctrl = (d.own == bra_pkg::OWN_DTC);
      d.grant.cpu = (d.own == bra_pkg::OWN_CPU);

      // axi write: address and data in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_ok = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_ok = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_ok && q.w_ok && !q.bvalid) begin
         d.aw_ok = 1'b0;
         d.w_ok = 1'b0;
         d.bvalid = 1'b1;
         if (q.awaddr == `BRA_CTRL_OFS) begin
            d.bresp = `BRA_RESP_OKAY;
            if (q.wstrb[0]) begin
               d.ctrl = q.wdata[2:0];
            end
         end else if (q.awaddr == `BRA_STAT_OFS) begin
            d.bresp = `BRA_RESP_OKAY;
         end else begin
            d.bresp = `BRA_RESP_SLVERR;
         end
      end
      d.awready = !d.aw_ok && !d.bvalid;
      d.wready = !d.w_ok && !d.bvalid;

      // axi read
      if (s_axi_rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         d.rvalid = 1'b1;
         d.rdata = 32'h0;
         d.rresp = `BRA_RESP_OKAY;
         if (s_axi_araddr == `BRA_CTRL_OFS) begin
            d.rdata[2:0] = q.ctrl;
         end else if (s_axi_araddr == `BRA_STAT_OFS) begin
            d.rdata[`BRA_STAT_REL] = (q.rel == bra_pkg::REL_HELD);
            d.rdata[`BRA_STAT_ACK] = q.ack_n;
            d.rdata[`BRA_STAT_DROP] = q.drop_n;
            d.rdata[`BRA_STAT_OWN +: 2] = q.own;
         end else begin
            d.rresp = `BRA_RESP_SLVERR;
         end
      end
      d.arready = !d.rvalid;

      // drop output pin routing follows the control register
      d.drop_a_oe_n = !(d.ctrl[`BRA_CTRL_DROPEN]
         && !d.ctrl[`BRA_CTRL_PINSEL]);
      d.drop_b_oe_n = !(d.ctrl[`BRA_CTRL_DROPEN]
         && d.ctrl[`BRA_CTRL_PINSEL]);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // no bus cycle survives a reset
         q <= '0;
         q.rel <= bra_pkg::REL_IDLE;
         q.own <= bra_pkg::OWN_CPU;
         q.ctrl <= `BRA_CTRL_RST;
         q.ack_n <= 1'b1;
         q.drop_n <= 1'b1;
         q.drop_a_oe_n <= 1'b1;
         q.drop_b_oe_n <= 1'b1;
         q.grant.cpu <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign s_axi_awready = q.awready;
   assign s_axi_wready = q.wready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = q.arready;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign ext_bus_ack_n = q.ack_n;
   assign request_drop_n = q.drop_n;
   assign request_drop_a_oe_n = q.drop_a_oe_n;
   assign request_drop_b_oe_n = q.drop_b_oe_n;
   // every pin comes straight from a flop, no glitching decode
   assign bus_oe_n = q.bus_oe_n;
   assign dma_ack_force_high = q.dma_hi;
   assign ext_cycle_go = q.go_ext;
   assign refresh_go = q.go_rfsh;
   assign grant = q.grant;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_NO_REL_DISABLED: assert property (
      (q.rel == bra_pkg::REL_IDLE
         && !(q.ctrl[`BRA_CTRL_RLE] && ext_expanded))
      |=> q.ack_n)
      else $error("bus released while release disabled");
   AST_ACK_LOW: assert property (
      (q.rel == bra_pkg::REL_IDLE && rel_start)
      |=> !ext_bus_ack_n && bus_oe_n && dma_ack_force_high)
      else $error("acknowledge or float missing");
   AST_NO_EXT_GO: assert property (
      !q.ack_n |-> !ext_cycle_go)
      else $error("external cycle started during release");
   AST_NO_RFSH: assert property (
      !q.ack_n |-> !refresh_go)
      else $error("refresh started during release");
   AST_DROP_LOW: assert property (
      (q.rel == bra_pkg::REL_HELD && !ext_bus_request_n
         && q.ctrl[`BRA_CTRL_DROPEN] && ext_access_req)
      |=> !request_drop_n)
      else $error("drop output not driven low");
   AST_ACK_RISE: assert property (
      (q.rel == bra_pkg::REL_HELD && ext_bus_request_n)
      |=> ext_bus_ack_n)
      else $error("acknowledge did not rise");
   AST_DROP_RISE: assert property (
      ($rose(ext_bus_ack_n) && !request_drop_n)
      |=> !request_drop_n ##1 request_drop_n)
      else $error("drop output timing wrong");
   AST_REL_FIRST: assert property (
      (q.rel == bra_pkg::REL_IDLE && rel_start && ext_access_req)
      |=> !ext_cycle_go && !ext_bus_ack_n)
      else $error("external access beat release");
   AST_RFSH_FIRST: assert property (
      (q.rel == bra_pkg::REL_IDLE && rel_ok && refresh_req)
      |=> refresh_go && ext_bus_ack_n)
      else $error("release beat refresh");
   AST_PIN_SEL: assert property (
      (q.ctrl[`BRA_CTRL_DROPEN] && q.ctrl[`BRA_CTRL_PINSEL])
      |-> !request_drop_b_oe_n && request_drop_a_oe_n)
      else $error("drop output on wrong pin");
   AST_DMA_PRIO: assert property (
      (own_free && mst.dma_req) |=> grant.dma && !grant.cpu)
      else $error("DMA not granted first");
   AST_CPU_SPLIT: assert property (
      (grant.cpu && mst.cpu_split_busy && !mst.cpu_sleep)
      |=> grant.cpu)
      else $error("CPU lost bus inside split access");
   AST_CPU_SLEEP: assert property (
      (grant.cpu && mst.cpu_sleep && mst.dtc_req && !mst.dma_req)
      |=> grant.data_transfer_ctrl)
      else $error("sleeping CPU kept the bus");
   AST_DTC_HOLD: assert property (
      (grant.data_transfer_ctrl && mst.dtc_req && !mst.dtc_step_done)
      |=> grant.data_transfer_ctrl)
      else $error("transfer controller lost bus mid step");
   AST_BURST_HOLD: assert property (
      (grant.dma && mst.dma_req && !mst.dma_all_done
         && mst.dma_mode == bra_pkg::DMA_BURST)
      |=> grant.dma)
      else $error("burst DMA lost bus early");
   AST_BUSY_HOLD: assert property (
      (q.rel == bra_pkg::REL_IDLE && ext_cycle_busy)
      |=> ext_bus_ack_n)
      else $error("bus released mid cycle");

   COV_RELEASE: cover property (
      !ext_bus_ack_n ##[1:20] $rose(ext_bus_ack_n));
   COV_DROP: cover property (
      !request_drop_n ##1 $rose(ext_bus_ack_n));
   COV_HANDOVER: cover property (grant.cpu ##1 grant.dma);

endmodule // bra_arbiter

// ### testbench/bra_ext_master.sv
`timescale 1ns/100ps
// ----------------------------------------
// outside master asking for the external bus
// ----------------------------------------
module bra_ext_master (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bench control
   input wire logic want,
   input wire logic obey_drop,
   input wire logic [7:0] hold,
   // handshake pins
   input wire logic ext_bus_ack_n,
   input wire logic request_drop_n,
   output logic ext_bus_request_n
);
   logic [1:0] st;
   logic [7:0] cnt;
   initial begin
      st = 2'h0;
      cnt = 8'h00;
      ext_bus_request_n = 1'b1;
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         st <= 2'h0;
         ext_bus_request_n <= 1'b1;
      end else begin
         case (st)
            2'h0: if (want) begin
               ext_bus_request_n <= 1'b0;
               st <= 2'h1;
            end
            2'h1: if (!ext_bus_ack_n) begin
               st <= 2'h2;
               cnt <= 8'h00;
            end else if (!want) begin
               ext_bus_request_n <= 1'b1;
               st <= 2'h0;
            end
            2'h2: begin
               cnt <= cnt + 8'h01;
               // a slow master ignores the drop request until hold ends
               if (cnt >= hold || (obey_drop && !request_drop_n)) begin
                  ext_bus_request_n <= 1'b1;
                  st <= 2'h3;
               end
            end
            default: if (ext_bus_ack_n) st <= 2'h0;
         endcase
      end
   end
endmodule // bra_ext_master

// ### testbench/tb_top.sv
`timescale 1ns/100ps
`include "bra_defs.svh"
module tb_top;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, hold = 8'hFF;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic expd = 1'b0, acc = 1'b0, busy = 1'b0, rfr = 1'b0;
   logic want = 1'b0, obey = 1'b0, req_n;
   logic ack_n, drop_n, oea, oeb, bus_oe_n, dma_hi, cyc_go, rf_go;
   bra_pkg::bra_mst_s mst = '0;
   bra_pkg::bra_grant_s grant;
   int n_mismatch = 0, n_compared = 0, cycles = 0, seed = 32'h1B58F5F0;
   always #5 aclk = ~aclk;
   bra_arbiter bra_arbiter_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_expanded(expd),
      .ext_access_req(acc), .ext_cycle_busy(busy), .refresh_req(rfr),
      .mst(mst), .grant(grant), .ext_bus_request_n(req_n),
      .ext_bus_ack_n(ack_n), .request_drop_n(drop_n),
      .request_drop_a_oe_n(oea), .request_drop_b_oe_n(oeb),
      .bus_oe_n(bus_oe_n), .dma_ack_force_high(dma_hi),
      .ext_cycle_go(cyc_go), .refresh_go(rf_go));
   bra_ext_master bra_ext_master_i (.aclk(aclk), .aresetn(aresetn),
      .want(want), .obey_drop(obey), .hold(hold), .ext_bus_ack_n(ack_n),
      .request_drop_n(drop_n), .ext_bus_request_n(req_n));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic stop_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // a hang past this many cycles is counted as a failure
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   function automatic logic [31:0] ctrl_val(input logic e, d, p);
      return (32'(e) << `BRA_CTRL_RLE) | (32'(d) << `BRA_CTRL_DROPEN) |
         (32'(p) << `BRA_CTRL_PINSEL);
   endfunction
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic wait_ack(input logic lv);
      int i;
      i = 0;
      while (ack_n !== lv && i < 40) begin
         @(posedge aclk);
         i++;
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      cyc(8);
      aresetn <= 1'b1;
      cyc(2);
      axi_rd(`BRA_CTRL_OFS, d, r);
      check(d, `BRA_CTRL_RST);
      axi_rd(`BRA_STAT_OFS, d, r);
      check(d, (32'h1 << `BRA_STAT_ACK) | (32'h1 << `BRA_STAT_DROP));
      axi_rd(8'h0C, d, r);
      check(r, `BRA_RESP_SLVERR);
      axi_wr(8'h10, 32'h1, 4'hF, r);
      check(r, `BRA_RESP_SLVERR);
      // no all-stopped module-stop pattern is ever loaded here
      expd <= 1'b1;
      want <= 1'b1;
      cyc(10);
      check(ack_n, 1'b1);
      want <= 1'b0;
      axi_wr(`BRA_CTRL_OFS, ctrl_val(1, 0, 0), 4'hE, r);
      axi_rd(`BRA_CTRL_OFS, d, r);
      check(d, `BRA_CTRL_RST);
      axi_wr(`BRA_CTRL_OFS, ctrl_val(1, 0, 0), 4'hF, r);
      expd <= 1'b0;
      want <= 1'b1;
      cyc(10);
      check(ack_n, 1'b1);
      expd <= 1'b1;
      busy <= 1'b1;
      cyc(10);
      check(ack_n, 1'b1);
      busy <= 1'b0;
      wait_ack(1'b0);
      check({ack_n, bus_oe_n, dma_hi}, 3'b011);
      // internal masters keep arbitrating while the bus is out
      mst.dtc_req <= 1'b1;
      mst.cpu_sleep <= 1'b1;
      cyc(3);
      check(grant, 3'b010);
      mst.cpu_sleep <= 1'b0;
      mst.dma_req <= 1'b1;
      cyc(3);
      check(grant, 3'b010);
      mst.dtc_step_done <= 1'b1;
      cyc(1);
      mst.dtc_step_done <= 1'b0;
      cyc(3);
      check(grant, 3'b100);
      mst.dma_req <= 1'b0;
      cyc(3);
      check(grant, 3'b010);
      // let the cpu own the bus before the split access starts
      mst.dtc_req <= 1'b0;
      cyc(2);
      check(grant, 3'b001);
      mst.dma_req <= 1'b1;
      mst.cpu_split_busy <= 1'b1;
      mst.cpu_cycle_end <= 1'b1;
      cyc(1);
      mst.cpu_cycle_end <= 1'b0;
      cyc(3);
      check(grant, 3'b001);
      mst.cpu_split_busy <= 1'b0;
      mst.cpu_cycle_end <= 1'b1;
      cyc(1);
      mst.cpu_cycle_end <= 1'b0;
      cyc(3);
      check(grant, 3'b100);
      mst.dma_mode <= bra_pkg::DMA_BURST;
      mst.dtc_req <= 1'b1;
      mst.dma_block_done <= 1'b1;
      cyc(1);
      mst.dma_block_done <= 1'b0;
      cyc(2);
      check(grant, 3'b100);
      mst.dma_mode <= bra_pkg::DMA_STEAL;
      mst.dma_req <= 1'b0;
      mst.dma_xfer_done <= 1'b1;
      cyc(1);
      mst.dma_xfer_done <= 1'b0;
      cyc(2);
      check(grant, 3'b010);
      mst.dtc_req <= 1'b0;
      mst.dma_req <= 1'b0;
      acc <= 1'b1;
      cyc(3);
      check({cyc_go, drop_n}, 2'b01);
      axi_wr(`BRA_CTRL_OFS, ctrl_val(1, 1, 0), 4'hF, r);
      cyc(2);
      check({drop_n, oea, oeb}, 3'b001);
      axi_wr(`BRA_CTRL_OFS, ctrl_val(1, 1, 1), 4'hF, r);
      rfr <= 1'b1;
      cyc(3);
      check({oea, oeb, rf_go}, 3'b100);
      want <= 1'b0;
      obey <= 1'b1;
      wait_ack(1'b1);
      check(ack_n, 1'b1);
      cyc(1);
      check(drop_n, 1'b0);
      cyc(1);
      check(drop_n, 1'b1);
      cyc(1);
      check({rf_go, cyc_go}, 2'b11);
      want <= 1'b1;
      cyc(10);
      check({ack_n, rf_go}, 2'b11);
      rfr <= 1'b0;
      wait_ack(1'b0);
      cyc(2);
      check({ack_n, cyc_go}, 2'b00);
      want <= 1'b0;
      wait_ack(1'b1);
      acc <= 1'b0;
      // random hold lengths, patience and master traffic
      repeat (8) begin
         hold <= 8'($unsigned($random(seed)) % 8 + 1);
         obey <= 1'($random(seed));
         acc <= 1'($random(seed));
         mst <= bra_pkg::bra_mst_s'($random(seed));
         want <= 1'b1;
         wait_ack(1'b0);
         check({ack_n, bus_oe_n, cyc_go}, 3'b010);
         check($countones(grant), 1);
         want <= 1'b0;
         wait_ack(1'b1);
         check(ack_n, 1'b1);
         cyc(3);
      end
      want <= 1'b1;
      wait_ack(1'b0);
      aresetn <= 1'b0;
      cyc(2);
      check({ack_n, bus_oe_n, grant}, 5'b10001);
      aresetn <= 1'b1;
      want <= 1'b0;
      axi_rd(`BRA_CTRL_OFS, d, r);
      check(d, `BRA_CTRL_RST);
      stop_test();
   end
endmodule // tb_top
